// *** verilog/au8_defs.vh ***
// Constants shared by the 8-bit arithmetic unit and its testbench.
// Assumes inclusion by bare name from files under verilog/ and tb/.
`ifndef AU8_DEFS_VH
`define AU8_DEFS_VH

// Register byte offsets on the AHB-Lite slave
`define AU8_OFS_CMD 12'h000
`define AU8_OFS_IMM 12'h004
`define AU8_OFS_WREG 12'h008
`define AU8_OFS_FLAGS 12'h00c
`define AU8_OFS_STAT 12'h010
`define AU8_OFS_MEM 12'h040

// Command register fields
`define AU8_CMD_OP_LSB 0
`define AU8_CMD_OP_W 5
`define AU8_CMD_ADR_LSB 8

// Flag register bit positions
`define AU8_FLG_Z 0
`define AU8_FLG_C 1
`define AU8_FLG_HC 2
`define AU8_FLG_OVF 3

// Status register bit positions
`define AU8_STAT_BAD 0
`define AU8_STAT_CNT_LSB 8

// Reset values
`define AU8_RST_BYTE 8'h00
`define AU8_RST_FLAGS 4'h0

// Operation codes written to the command register
`define AU8_OP_ADD_AI 5'h00
`define AU8_OP_ADD_AM 5'h01
`define AU8_OP_ADD_MA 5'h02
`define AU8_OP_ADDC_AM 5'h03
`define AU8_OP_ADDC_MA 5'h04
`define AU8_OP_ADDC_A 5'h05
`define AU8_OP_ADDC_M 5'h06
`define AU8_OP_NADD_AM 5'h07
`define AU8_OP_NADD_MA 5'h08
`define AU8_OP_SUB_AI 5'h09
`define AU8_OP_SUB_AM 5'h0a
`define AU8_OP_SUB_MA 5'h0b
`define AU8_OP_SUBC_AM 5'h0c
`define AU8_OP_SUBC_MA 5'h0d
`define AU8_OP_SUBC_A 5'h0e
`define AU8_OP_SUBC_M 5'h0f
`define AU8_OP_INC_M 5'h10
`define AU8_OP_DEC_M 5'h11
`define AU8_OP_CLR_M 5'h12

`endif

// *** verilog/au8_adder.v ***
// Combinational 8-bit adder/subtractor with flag generation.
// Assumes the caller supplies operands already chosen; no clock here.
module au8_adder (
    input wire [7:0] x,
    input wire [7:0] y,
    input wire cin,
    input wire sub,
    output wire [7:0] res,
    output wire flag_z,
    output wire flag_c,
    output wire flag_hc,
    output wire flag_ovf
);
    wire [7:0] y_eff;
    wire c_eff;
    wire [8:0] sum9;
    wire [4:0] sum5;

    // Subtraction adds the two's complement: invert y, carry-in is not-borrow
    assign y_eff = sub ? ~y : y;
    assign c_eff = sub ? ~cin : cin;
    assign sum9 = {1'b0, x} + {1'b0, y_eff} + {8'h00, c_eff};
    assign sum5 = {1'b0, x[3:0]} + {1'b0, y_eff[3:0]} + {4'h0, c_eff};
    assign res = sum9[7:0];

    // A missing carry out of an inverted-operand add is the borrow
    assign flag_c = sub ? ~sum9[8] : sum9[8];
    assign flag_hc = sub ? ~sum5[4] : sum5[4];
    assign flag_z = (sum9[7:0] == 8'h00);
    // Overflow: both addends share a sign that the result does not
    assign flag_ovf = (x[7] == y_eff[7]) && (sum9[7] != x[7]);
endmodule

// *** verilog/au8_top.v ***
// 8-bit arithmetic unit with working register, flags and a small data memory,
// reached over an AHB-Lite slave port. Assumes one master, word transfers only.
//
// Contract
// - Immediate add: working register plus immediate
// - Memory add into working register
// - Memory add written back to memory
// - Add with carry into working register
// - Add with carry into memory
// - Working register plus carry only
// - Memory byte plus carry only
// - Memory minus working register into register
// - Working register minus memory into memory
// - Immediate subtract via two's complement add
// - Register minus memory into register
// - Memory minus register into memory
// - Register minus memory minus carry
// - Memory minus register minus carry
// - Working register minus carry only
// - Memory byte minus carry only
// - Increment memory byte in place
// - Decrement memory byte in place
// - Clear writes zero to memory
// - Every operation updates all four flags
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
`include "au8_defs.vh"

module au8_top #(
    parameter MEM_AW = 4
) (
    input wire CLK,
    input wire SRST,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output reg [31:0] HRDATA,
    output reg HREADYOUT,
    output reg HRESP
);
    localparam MEM_DEPTH = 1 << MEM_AW;
    // Bus states; S_DATA is the data phase wait state that every access takes,
    // S_EXEC the extra wait in which a launched command writes its result
    localparam S_IDLE = 2'b00;
    localparam S_DATA = 2'b01;
    localparam S_EXEC = 2'b10;

    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [11:0] addr_r;
    reg write_r;
    reg [7:0] wreg_r;
    reg [7:0] imm_r;
    reg flg_z_r;
    reg flg_c_r;
    reg flg_hc_r;
    reg flg_ovf_r;
    reg bad_r;
    reg [7:0] cnt_r;
    reg [4:0] op_r;
    reg [MEM_AW-1:0] madr_r;
    reg [7:0] mem_r [0:MEM_DEPTH-1];

    wire take;
    wire [7:0] mbyte;
    reg [7:0] op_x;
    reg [7:0] op_y;
    reg op_cin;
    reg op_sub;
    reg op_to_mem;
    reg op_ok;
    wire [7:0] alu_res;
    wire alu_z;
    wire alu_c;
    wire alu_hc;
    wire alu_ovf;
    integer i;

    // Hit test for the data memory window; addresses outside it and outside the registers read as zero
    function mem_hit;
        input [11:0] a;
        begin
            mem_hit = (a >= `AU8_OFS_MEM) &&
                      (a < (`AU8_OFS_MEM + (MEM_DEPTH << 2)));
        end
    endfunction

    // Byte index inside the memory window; only meaningful on a hit
    function [MEM_AW-1:0] mem_idx;
        input [11:0] a;
        reg [11:0] d;
        begin
            d = a - `AU8_OFS_MEM;
            mem_idx = d[MEM_AW+1:2];
        end
    endfunction

    // Accept an address phase only when idle and the bus is ready
    assign take = (state_r == S_IDLE) && HSEL && HTRANS[1] && HREADY;
    assign mbyte = mem_r[madr_r];

    // Bus sequencing: every access takes one wait state, commands a second
    always @* begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE: begin
                if (take) begin
                    state_nxt = S_DATA;
                end
            end
            S_DATA: begin
                if (write_r && (addr_r == `AU8_OFS_CMD)) begin
                    state_nxt = S_EXEC;
                end else begin
                    state_nxt = S_IDLE;
                end
            end
            S_EXEC: state_nxt = S_IDLE;
            default: state_nxt = S_IDLE;
        endcase
    end

    // Operand routing per operation code
    always @* begin
        op_x = wreg_r;
        op_y = 8'h00;
        op_cin = 1'b0;
        op_sub = 1'b0;
        op_to_mem = 1'b0;
        op_ok = 1'b1;
        case (op_r)
            `AU8_OP_ADD_AI: begin
                op_y = imm_r;
            end
            `AU8_OP_ADD_AM: begin
                op_y = mbyte;
            end
            `AU8_OP_ADD_MA: begin
                op_y = mbyte;
                op_to_mem = 1'b1;
            end
            `AU8_OP_ADDC_AM: begin
                op_y = mbyte;
                op_cin = flg_c_r;
            end
            `AU8_OP_ADDC_MA: begin
                op_y = mbyte;
                op_cin = flg_c_r;
                op_to_mem = 1'b1;
            end
            `AU8_OP_ADDC_A: begin
                op_cin = flg_c_r;
            end
            `AU8_OP_ADDC_M: begin
                op_x = mbyte;
                op_cin = flg_c_r;
                op_to_mem = 1'b1;
            end
            `AU8_OP_NADD_AM: begin
                // Negated register plus memory is memory minus register
                op_x = mbyte;
                op_y = wreg_r;
                op_sub = 1'b1;
            end
            `AU8_OP_NADD_MA: begin
                op_y = mbyte;
                op_sub = 1'b1;
                op_to_mem = 1'b1;
            end
            `AU8_OP_SUB_AI: begin
                op_y = imm_r;
                op_sub = 1'b1;
            end
            `AU8_OP_SUB_AM: begin
                op_y = mbyte;
                op_sub = 1'b1;
            end
            `AU8_OP_SUB_MA: begin
                op_x = mbyte;
                op_y = wreg_r;
                op_sub = 1'b1;
                op_to_mem = 1'b1;
            end
            `AU8_OP_SUBC_AM: begin
                op_y = mbyte;
                op_cin = flg_c_r;
                op_sub = 1'b1;
            end
            `AU8_OP_SUBC_MA: begin
                op_x = mbyte;
                op_y = wreg_r;
                op_cin = flg_c_r;
                op_sub = 1'b1;
                op_to_mem = 1'b1;
            end
            `AU8_OP_SUBC_A: begin
                op_cin = flg_c_r;
                op_sub = 1'b1;
            end
            `AU8_OP_SUBC_M: begin
                op_x = mbyte;
                op_cin = flg_c_r;
                op_sub = 1'b1;
                op_to_mem = 1'b1;
            end
            `AU8_OP_INC_M: begin
                op_x = mbyte;
                op_y = 8'h01;
                op_to_mem = 1'b1;
            end
            `AU8_OP_DEC_M: begin
                op_x = mbyte;
                op_y = 8'h01;
                op_sub = 1'b1;
                op_to_mem = 1'b1;
            end
            `AU8_OP_CLR_M: begin
                // Zero plus zero gives the zero result and its flags
                op_x = 8'h00;
                op_to_mem = 1'b1;
            end
            default: begin
                op_ok = 1'b0;
            end
        endcase
    end

    au8_adder u_adder (
        .x(op_x),
        .y(op_y),
        .cin(op_cin),
        .sub(op_sub),
        .res(alu_res),
        .flag_z(alu_z),
        .flag_c(alu_c),
        .flag_hc(alu_hc),
        .flag_ovf(alu_ovf)
    );

    // Bus handshake, captured address phase and read data
    always @(posedge CLK) begin
        if (SRST) begin
            state_r <= S_IDLE;
            addr_r <= 12'h000;
            write_r <= 1'b0;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            HRDATA <= 32'h00000000;
        end else begin
            state_r <= state_nxt;
            HRESP <= 1'b0;
            if (take) begin
                addr_r <= HADDR[11:0];
                write_r <= HWRITE;
                HREADYOUT <= 1'b0;
            end else if (state_nxt == S_IDLE) begin
                HREADYOUT <= 1'b1;
            end
            // Read data is loaded while the wait state holds the master
            if (state_r == S_DATA && !write_r) begin
                HRDATA <= 32'h00000000;
                if (addr_r == `AU8_OFS_CMD) begin
                    HRDATA[`AU8_CMD_OP_LSB +: `AU8_CMD_OP_W] <= op_r;
                    HRDATA[`AU8_CMD_ADR_LSB +: MEM_AW] <= madr_r;
                end else if (addr_r == `AU8_OFS_IMM) begin
                    HRDATA[7:0] <= imm_r;
                end else if (addr_r == `AU8_OFS_WREG) begin
                    HRDATA[7:0] <= wreg_r;
                end else if (addr_r == `AU8_OFS_FLAGS) begin
                    HRDATA[`AU8_FLG_Z] <= flg_z_r;
                    HRDATA[`AU8_FLG_C] <= flg_c_r;
                    HRDATA[`AU8_FLG_HC] <= flg_hc_r;
                    HRDATA[`AU8_FLG_OVF] <= flg_ovf_r;
                end else if (addr_r == `AU8_OFS_STAT) begin
                    HRDATA[`AU8_STAT_BAD] <= bad_r;
                    HRDATA[`AU8_STAT_CNT_LSB +: 8] <= cnt_r;
                end else if (mem_hit(addr_r)) begin
                    HRDATA[7:0] <= mem_r[mem_idx(addr_r)];
                end
            end
        end
    end

    // Register writes from the bus and results from the datapath
    always @(posedge CLK) begin
        if (SRST) begin
            wreg_r <= `AU8_RST_BYTE;
            imm_r <= `AU8_RST_BYTE;
            op_r <= 5'h00;
            madr_r <= {MEM_AW{1'b0}};
            {flg_ovf_r, flg_hc_r, flg_c_r, flg_z_r} <= `AU8_RST_FLAGS;
            bad_r <= 1'b0;
            cnt_r <= 8'h00;
            for (i = 0; i < MEM_DEPTH; i = i + 1) begin
                mem_r[i] <= `AU8_RST_BYTE;
            end
        end else if (state_r == S_DATA && write_r) begin
            // Data phase write; bits above each register's width are dropped
            if (addr_r == `AU8_OFS_CMD) begin
                op_r <= HWDATA[`AU8_CMD_OP_LSB +: `AU8_CMD_OP_W];
                madr_r <= HWDATA[`AU8_CMD_ADR_LSB +: MEM_AW];
            end else if (addr_r == `AU8_OFS_IMM) begin
                imm_r <= HWDATA[7:0];
            end else if (addr_r == `AU8_OFS_WREG) begin
                wreg_r <= HWDATA[7:0];
            end else if (addr_r == `AU8_OFS_FLAGS) begin
                flg_z_r <= HWDATA[`AU8_FLG_Z];
                flg_c_r <= HWDATA[`AU8_FLG_C];
                flg_hc_r <= HWDATA[`AU8_FLG_HC];
                flg_ovf_r <= HWDATA[`AU8_FLG_OVF];
            end else if (addr_r == `AU8_OFS_STAT) begin
                // Write one clears the bad-operation flag
                if (HWDATA[`AU8_STAT_BAD]) begin
                    bad_r <= 1'b0;
                end
            end else if (mem_hit(addr_r)) begin
                mem_r[mem_idx(addr_r)] <= HWDATA[7:0];
            end
        end else if (state_r == S_EXEC) begin
            if (op_ok) begin
                if (op_to_mem) begin
                    mem_r[madr_r] <= alu_res;
                end else begin
                    wreg_r <= alu_res;
                end
                // All four flags follow the result, clear included
                flg_z_r <= alu_z;
                flg_c_r <= alu_c;
                flg_hc_r <= alu_hc;
                flg_ovf_r <= alu_ovf;
                cnt_r <= cnt_r + 8'h01;
            end else begin
                // Unknown code leaves data and flags untouched
                bad_r <= 1'b1;
            end
        end
    end
endmodule

// *** tb/au8_top_chk.sv ***
// Bus timing checker for the 8-bit arithmetic unit.
// Assumes HREADY is tied to HREADYOUT; bound from the bench top.
module au8_top_chk (
    input logic CLK,
    input logic SRST,
    input logic HSEL,
    input logic [31:0] HADDR,
    input logic [1:0] HTRANS,
    input logic HWRITE,
    input logic HREADY,
    input logic [31:0] HRDATA,
    input logic HREADYOUT,
    input logic HRESP
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking dc @(posedge CLK);
    endclocking
    default disable iff (SRST);
    // Accepted address phase; a command write needs one extra execute cycle
    wire acc = HSEL && HTRANS[1] && HREADY;
    wire is_cmd = HWRITE && (HADDR[11:0] == 12'h000);
    AST_WAIT_AFTER_TAKE: assert property (acc |=> !HREADYOUT)
        else $error("no wait state after an accepted transfer");
    AST_RW_TWO_EDGES: assert property (acc && !is_cmd |=> !HREADYOUT ##1 HREADYOUT)
        else $error("register access did not finish in two edges");
    AST_CMD_THREE_EDGES: assert property (acc && is_cmd |=> !HREADYOUT [*2] ##1 HREADYOUT)
        else $error("command did not finish in three edges");
    AST_IDLE_READY: assert property (!acc && HREADYOUT |=> HREADYOUT)
        else $error("wait state without a transfer");
    AST_OKAY: assert property (HRESP == 1'b0)
        else $error("error response seen");
    AST_RDATA_HOLD: assert property (HREADYOUT && $past(HREADYOUT) |-> $stable(HRDATA))
        else $error("read data moved while idle");
    AST_UPPER_ZERO: assert property ($rose(HREADYOUT) |-> HRDATA[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    AST_RESET_STATE: assert property ($past(SRST) |-> HREADYOUT && HRDATA == 32'h0)
        else $error("bus outputs wrong after reset");
endmodule

// *** tb/au8_ahb_mst.sv ***
// AHB-Lite master standing in for the instruction decoder side.
// Assumes HREADY is the slave's HREADYOUT; callers enter just after a rising edge.
module au8_ahb_mst (
    input logic CLK,
    input logic HREADY,
    input logic [31:0] HRDATA,
    output logic HSEL = 1'b0,
    output logic [31:0] HADDR = 32'h0,
    output logic [1:0] HTRANS = 2'b00,
    output logic HWRITE = 1'b0,
    output logic [2:0] HSIZE = 3'b010,
    output logic [31:0] HWDATA = 32'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    logic hung = 1'b0;
    // Hold each phase until ready is sampled; a bound stops a hang
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        HSEL <= 1'b1;
        HTRANS <= 2'b10;
        HWRITE <= wr;
        HADDR <= {20'h00000, a};
        @(posedge CLK);
        while (HREADY !== 1'b1 && n < 64) begin
            @(posedge CLK);
            n++;
        end
        HSEL <= 1'b0;
        HTRANS <= 2'b00;
        HWDATA <= d;
        @(posedge CLK);
        while (HREADY !== 1'b1 && n < 64) begin
            @(posedge CLK);
            n++;
        end
        q = HRDATA;
        HWDATA <= ~d; // Released data is scrambled so no stale value is trusted
        if (n >= 64) hung = 1'b1;
    endtask
endmodule

// *** tb/au8_top_tb.sv ***
// Self-checking bench for the 8-bit arithmetic unit over its register bus.
// Assumes the design under verilog/ and the master model and checker under tb/.
`include "au8_defs.vh"
module au8_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    wire hsel, hwrite, hrdy, hresp;
    wire [31:0] haddr, hwdata, hrdata;
    wire [1:0] htrans;
    wire [2:0] hsize;
    int err_count = 0;
    int total_checks = 0;
    logic [7:0] ops_done = 8'h00;
    au8_top #(.MEM_AW(2)) u_au8_top (.CLK(clk), .SRST(srst), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hrdy),
        .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp));
    au8_ahb_mst u_au8_ahb_mst (.CLK(clk), .HREADY(hrdy), .HRDATA(hrdata), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q);
        u_au8_ahb_mst.xfer(w, a, d, q);
        if (u_au8_ahb_mst.hung) begin
            err_count++;
            wrap_up();
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        total_checks++;
        if (q !== e) begin
            err_count++;
            $display("wrong value at %0t: addr %h got %h expected %h", $time, a, q, e);
        end
    endtask
    // Reference: returns {overflow, half carry, carry, zero, result to memory, result}
    function automatic logic [12:0] model(input logic [4:0] op, input logic [7:0] a, m, i,
        input logic c);
        logic [7:0] x, y, ye;
        logic cu, sb, tm, ci;
        logic [8:0] s;
        logic [4:0] h;
        case (op)
            `AU8_OP_ADD_AI: {x, y, cu, sb, tm} = {a, i, 3'b000};
            `AU8_OP_ADD_AM: {x, y, cu, sb, tm} = {a, m, 3'b000};
            `AU8_OP_ADD_MA: {x, y, cu, sb, tm} = {a, m, 3'b001};
            `AU8_OP_ADDC_AM: {x, y, cu, sb, tm} = {a, m, c, 2'b00};
            `AU8_OP_ADDC_MA: {x, y, cu, sb, tm} = {a, m, c, 2'b01};
            `AU8_OP_ADDC_A: {x, y, cu, sb, tm} = {a, 8'h00, c, 2'b00};
            `AU8_OP_ADDC_M: {x, y, cu, sb, tm} = {m, 8'h00, c, 2'b01};
            `AU8_OP_NADD_AM: {x, y, cu, sb, tm} = {m, a, 3'b010};
            `AU8_OP_NADD_MA: {x, y, cu, sb, tm} = {a, m, 3'b011};
            `AU8_OP_SUB_AI: {x, y, cu, sb, tm} = {a, i, 3'b010};
            `AU8_OP_SUB_AM: {x, y, cu, sb, tm} = {a, m, 3'b010};
            `AU8_OP_SUB_MA: {x, y, cu, sb, tm} = {m, a, 3'b011};
            `AU8_OP_SUBC_AM: {x, y, cu, sb, tm} = {a, m, c, 2'b10};
            `AU8_OP_SUBC_MA: {x, y, cu, sb, tm} = {m, a, c, 2'b11};
            `AU8_OP_SUBC_A: {x, y, cu, sb, tm} = {a, 8'h00, c, 2'b10};
            `AU8_OP_SUBC_M: {x, y, cu, sb, tm} = {m, 8'h00, c, 2'b11};
            `AU8_OP_INC_M: {x, y, cu, sb, tm} = {m, 8'h01, 3'b001};
            `AU8_OP_DEC_M: {x, y, cu, sb, tm} = {m, 8'h01, 3'b011};
            default: return {4'h1, 1'b1, 8'h00};
        endcase
        // Subtraction adds the inverse with inverted borrow, so carries flip to borrows
        ye = sb ? ~y : y;
        ci = sb ? ~cu : cu;
        s = {1'b0, x} + {1'b0, ye} + {8'h00, ci};
        h = {1'b0, x[3:0]} + {1'b0, ye[3:0]} + {4'h0, ci};
        return {(x[7] == ye[7]) && (s[7] != x[7]), h[4] ^ sb, s[8] ^ sb, s[7:0] == 8'h00, tm,
            s[7:0]};
    endfunction
    // Seed operands and carry, launch one command, read both destinations and flags
    task automatic run_op(input logic [4:0] op, input logic [7:0] a, m, i, input logic c);
        logic [12:0] e;
        logic [11:0] ma;
        e = model(op, a, m, i, c);
        ma = `AU8_OFS_MEM + {8'h00, op[1:0], 2'b00};
        wr(`AU8_OFS_WREG, {24'h0, a});
        wr(`AU8_OFS_IMM, {24'h0, i});
        wr(ma, {24'h0, m});
        wr(`AU8_OFS_FLAGS, {30'h0, c, 1'b0});
        wr(`AU8_OFS_CMD, {22'h0, op[1:0], 3'b000, op});
        ops_done++;
        rd_chk(`AU8_OFS_WREG, {24'h0, e[8] ? a : e[7:0]});
        rd_chk(ma, {24'h0, e[8] ? e[7:0] : m});
        rd_chk(`AU8_OFS_FLAGS, {28'h0, e[12:9]});
    endtask
    task automatic t_boundaries();
        // Hand-worked results and flags, independent of the reference function
        run_op(`AU8_OP_ADD_AI, 8'hf1, 8'h55, 8'h0f, 1'b1);
        rd_chk(`AU8_OFS_WREG, 32'h00000000);
        rd_chk(`AU8_OFS_FLAGS, 32'h00000007);
        run_op(`AU8_OP_SUB_AI, 8'h00, 8'h55, 8'h0f, 1'b0);
        rd_chk(`AU8_OFS_WREG, 32'h000000f1);
        rd_chk(`AU8_OFS_FLAGS, 32'h00000006);
        run_op(`AU8_OP_ADD_AM, 8'h7f, 8'h01, 8'h00, 1'b0);
        rd_chk(`AU8_OFS_FLAGS, 32'h0000000c);
        run_op(`AU8_OP_SUB_AM, 8'h80, 8'h01, 8'h00, 1'b1);
        rd_chk(`AU8_OFS_WREG, 32'h0000007f);
        rd_chk(`AU8_OFS_FLAGS, 32'h0000000c);
        run_op(`AU8_OP_INC_M, 8'h12, 8'hff, 8'h00, 1'b1);
        rd_chk(`AU8_OFS_MEM, 32'h00000000);
        rd_chk(`AU8_OFS_FLAGS, 32'h00000007);
        run_op(`AU8_OP_DEC_M, 8'h12, 8'h00, 8'h00, 1'b1);
        rd_chk(`AU8_OFS_MEM + 12'h004, 32'h000000ff);
        rd_chk(`AU8_OFS_FLAGS, 32'h00000006);
        run_op(`AU8_OP_CLR_M, 8'h12, 8'h9c, 8'h00, 1'b1);
        rd_chk(`AU8_OFS_MEM + 12'h008, 32'h00000000);
        rd_chk(`AU8_OFS_FLAGS, 32'h00000001);
        $display("boundary test done");
    endtask
    // Every opcode with carry clear and set, operands stepping through sign and nibble edges
    task automatic t_all_ops();
        logic [7:0] v;
        for (int k = 0; k < 38; k++) begin
            v = k[7:0] * 8'h29;
            run_op(k[5:1], 8'h3a + v, 8'h80 - v, v ^ 8'h7f, k[0]);
        end
        $display("all opcodes test done");
    endtask
    // Illegal opcode and unmapped space must leave data alone
    task automatic t_refused();
        wr(`AU8_OFS_WREG, 32'h0000005a);
        wr(`AU8_OFS_CMD, 32'h00000013);
        wr(12'h020, 32'h000000ff);
        rd_chk(12'h020, 32'h0);
        rd_chk(`AU8_OFS_WREG, 32'h0000005a);
        rd_chk(`AU8_OFS_CMD, 32'h00000013);
        rd_chk(`AU8_OFS_STAT, {16'h0, ops_done, 8'h01});
        wr(`AU8_OFS_STAT, 32'h00000001);
        rd_chk(`AU8_OFS_STAT, {16'h0, ops_done, 8'h00});
        wr(`AU8_OFS_IMM, 32'h000000a5);
        rd_chk(`AU8_OFS_IMM, 32'h000000a5);
        $display("refused access test done");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_boundaries();
        t_all_ops();
        t_refused();
        wrap_up();
    end
endmodule
bind au8_top au8_top_chk u_au8_top_chk (.CLK(CLK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP));
